/* File: hw/serial_rx_pkg.sv */
// constants and types shared by the serial receiver block
package serial_rx_pkg;
    // printed offsets are not all multiples of four: kept as indices
    localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c;
    localparam logic [7:0] IDX_RX_STATUS   = 8'h18;
    localparam logic [7:0] IDX_RX_DATA     = 8'h1a;
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_TX_STATUS   = 8'h98;
    localparam logic [7:0] IDX_BAUD_DIV    = 8'h99;
    // own registers for the sticky event interrupt group
    localparam logic [7:0] IDX_EVT_STATUS  = 8'ha0;
    localparam logic [7:0] IDX_EVT_CLEAR   = 8'ha1;
    localparam logic [7:0] IDX_EVT_ENABLE  = 8'ha2;
    localparam int ADDR_W = 10;

    // field positions
    localparam int FLG_RX_FULL   = 5;
    localparam int FLG_TX_EMPTY  = 4;
    localparam int RS_PORT_EN    = 7;
    localparam int RS_NINE_BIT   = 6;
    localparam int RS_CONT_RX    = 4;
    localparam int RS_FRAME_ERR  = 2;
    localparam int RS_OVERRUN    = 1;
    localparam int RS_NINTH      = 0;
    localparam int TS_SYNC_MODE  = 4;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_SHIFT_EMPTY = 1;
    localparam int EV_RX_DONE    = 0;
    localparam int EV_FRAME_ERR  = 1;
    localparam int EV_OVERRUN    = 2;
    localparam int EV_W          = 3;

    // reset values and writable masks
    localparam logic [7:0] RST_TX_STATUS = 8'h02;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [7:0] MASK_RX_WR    = 8'hf8;
    localparam logic [7:0] MASK_TX_WR    = 8'hf5;
    localparam logic [7:0] MASK_ENABLES  = 8'hf7;

    // baud: low speed divides by 64, high speed by 16 per bit
    localparam int OVS_LOW  = 64;
    localparam int OVS_HIGH = 16;
    localparam int OVS_W    = 6;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_t;
endpackage : serial_rx_pkg

/* File: hw/baud_tick_gen.sv */
// baud tick generator: one pulse per oversampled tick
module baud_tick_gen
    import serial_rx_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       run_i,
    input  wire logic [7:0] divisor_i,
    output logic            tick_o
);
    logic [7:0] cnt_q;

    // reload on divisor+1 clocks; stopped while the port is off
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b0;
        end
        else if (cnt_q == divisor_i)
        begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 8'h01;
            tick_o <= 1'b0;
        end
    end
endmodule // baud_tick_gen

/* File: hw/async_serial_receiver.sv */
// asynchronous serial receiver with register file and interrupts
// Function
// - interrupt flags set on their event regardless of any enable.
// - bit 5 of the flag register reads 1 while receive data waits.
// - bit 4 of the flag register reads 1 while the tx buffer is empty.
// - bit 3 of the flag register always reads zero.
// - port runs async when sync mode is clear and port enable set.
// - a finished frame sets the rx flag, irq only if rx enable or the event enable of rx done, overrun or, on a low stop bit, frame error is set.
// - nine-bit select takes a ninth bit, shown in status bit 0.
// - frames are accepted only while continuous receive is set.
// - overrun stays until continuous receive is cleared.
// - after reset unused bits read zero, tx status reads 0x02.
module async_serial_receiver
    import serial_rx_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_rx_pin_i,
    input  wire logic              tx_buffer_empty_i,
    output logic                   serial_rx_pin_oe_o,
    output logic                   irq_o
);
    logic [7:0]      irq_enables_q;
    logic [7:0]      rx_ctrl_q;
    logic [7:0]      tx_ctrl_q;
    logic [7:0]      baud_div_q;
    logic [7:0]      rx_data_q;
    logic            rx_full_q;
    logic            ninth_q;
    logic            frame_err_q;
    logic            overrun_q;
    logic [EV_W-1:0] evt_status_q;
    logic [EV_W-1:0] evt_enable_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic            aw_held_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            w_held_q;
    logic            wr_fire;
    logic [7:0]      wr_idx;
    logic            wr_ok;
    logic            rd_fire;
    logic [7:0]      rd_idx;
    logic [7:0]      rd_val;
    logic            rd_ok;
    logic            rd_data_pop;
    logic            port_async;
    logic            cont_rx;
    logic            tick;
    rx_state_t       state_q;
    logic [OVS_W-1:0] ovs_q;
    logic [3:0]      bit_q;
    logic [8:0]      shift_q;
    logic            frame_done;
    logic            stop_bad;
    logic            overrun_evt;
    logic            rx_evt;
    logic [OVS_W-1:0] ovs_last;

    // the receive pin is never driven by this block
    assign serial_rx_pin_oe_o = 1'b0;
    assign port_async = rx_ctrl_q[RS_PORT_EN]
                        & ~tx_ctrl_q[TS_SYNC_MODE];
    assign cont_rx    = rx_ctrl_q[RS_CONT_RX];
    assign ovs_last   = tx_ctrl_q[TS_HIGH_SPEED] ? OVS_W'(OVS_HIGH - 1)
                                                 : OVS_W'(OVS_LOW - 1);

    // write channel: address and data taken in either order
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
    assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_idx  = awaddr_q[9:2];
    assign wr_ok   = wstrb_q[0];

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_q <= 1'b0;
        end
    end

    // write response, slverr for unmapped indices
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            case (wr_idx)
                IDX_IRQ_FLAGS, IDX_RX_STATUS, IDX_RX_DATA,
                IDX_IRQ_ENABLES, IDX_TX_STATUS, IDX_BAUD_DIV,
                IDX_EVT_STATUS, IDX_EVT_CLEAR, IDX_EVT_ENABLE:
                    s_axi_bresp <= AXI_OKAY;
                default: s_axi_bresp <= AXI_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // control registers; only byte lane 0 carries data
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_enables_q <= RST_BYTE;
            rx_ctrl_q     <= RST_BYTE;
            tx_ctrl_q     <= RST_BYTE;
            baud_div_q    <= RST_BYTE;
            evt_enable_q  <= '0;
        end
        else if (wr_fire && wr_ok)
        begin
            case (wr_idx)
                IDX_IRQ_ENABLES: irq_enables_q <= wdata_q[7:0] & MASK_ENABLES;
                IDX_RX_STATUS:   rx_ctrl_q <= wdata_q[7:0] & MASK_RX_WR;
                IDX_TX_STATUS:   tx_ctrl_q <= wdata_q[7:0] & MASK_TX_WR;
                IDX_BAUD_DIV:    baud_div_q <= wdata_q[7:0];
                IDX_EVT_ENABLE:  evt_enable_q <= wdata_q[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // read channel, answered one cycle after the address is taken
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign rd_idx  = s_axi_araddr[9:2];
    assign rd_data_pop = rd_fire && (rd_idx == IDX_RX_DATA);

    always_comb
    begin
        rd_val = 8'h00;
        rd_ok  = 1'b1;
        case (rd_idx)
            IDX_IRQ_FLAGS:
            begin
                rd_val[FLG_RX_FULL]  = rx_full_q;
                rd_val[FLG_TX_EMPTY] = tx_buffer_empty_i;
            end
            IDX_RX_STATUS:
            begin
                rd_val = rx_ctrl_q;
                rd_val[RS_FRAME_ERR] = frame_err_q;
                rd_val[RS_OVERRUN]   = overrun_q;
                rd_val[RS_NINTH]     = ninth_q;
            end
            IDX_RX_DATA:     rd_val = rx_data_q;
            IDX_IRQ_ENABLES: rd_val = irq_enables_q;
            IDX_TX_STATUS:
            begin
                rd_val = tx_ctrl_q;
                rd_val[TS_SHIFT_EMPTY] = 1'b1;
            end
            IDX_BAUD_DIV:    rd_val = baud_div_q;
            IDX_EVT_STATUS:  rd_val[EV_W-1:0] = evt_status_q;
            IDX_EVT_CLEAR:   rd_val = 8'h00;
            IDX_EVT_ENABLE:  rd_val[EV_W-1:0] = evt_enable_q;
            default:         rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= AXI_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_val};
            s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    baud_tick_gen u_baud (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .run_i      (port_async),
        .divisor_i  (baud_div_q),
        .tick_o     (tick)
    );

    // receive sequencer, samples mid-bit on the oversampled ticks
    assign frame_done = tick && (state_q == RX_STOP) && (ovs_q == ovs_last);
    assign stop_bad   = ~serial_rx_pin_i;
    assign overrun_evt = frame_done & rx_full_q & ~rd_data_pop;
    assign rx_evt     = frame_done & ~overrun_evt;

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= RX_IDLE;
            ovs_q   <= '0;
            bit_q   <= 4'h0;
            shift_q <= 9'h000;
        end
        else if (!port_async || !cont_rx || overrun_q)
        begin
            state_q <= RX_IDLE;
            ovs_q   <= '0;
        end
        else if (tick)
        begin
            case (state_q)
                RX_IDLE:
                    if (!serial_rx_pin_i)
                    begin
                        state_q <= RX_START;
                        ovs_q   <= '0;
                    end
                RX_START:
                    if (ovs_q == (ovs_last >> 1))
                    begin
                        // false start glitch returns to idle
                        state_q <= serial_rx_pin_i ? RX_IDLE : RX_DATA;
                        ovs_q   <= '0;
                        bit_q   <= 4'h0;
                    end
                    else
                        ovs_q <= ovs_q + OVS_W'(1);
                RX_DATA:
                    if (ovs_q == ovs_last)
                    begin
                        ovs_q   <= '0;
                        shift_q <= {serial_rx_pin_i, shift_q[8:1]};
                        bit_q   <= bit_q + 4'h1;
                        if (bit_q == (rx_ctrl_q[RS_NINE_BIT] ? 4'h8 : 4'h7))
                            state_q <= RX_STOP;
                    end
                    else
                        ovs_q <= ovs_q + OVS_W'(1);
                RX_STOP:
                    if (ovs_q == ovs_last)
                        state_q <= RX_IDLE;
                    else
                        ovs_q <= ovs_q + OVS_W'(1);
                default: state_q <= RX_IDLE;
            endcase
        end
    end

    // receive buffer: reading the data register empties it
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_full_q   <= 1'b0;
            rx_data_q   <= RST_BYTE;
            ninth_q     <= 1'b0;
            frame_err_q <= 1'b0;
        end
        else if (rx_evt)
        begin
            rx_full_q   <= 1'b1;
            frame_err_q <= stop_bad;
            // nine bits fill the whole shifter, so the word sits one lower
            rx_data_q   <= rx_ctrl_q[RS_NINE_BIT] ? shift_q[7:0]
                                                  : shift_q[8:1];
            ninth_q     <= rx_ctrl_q[RS_NINE_BIT] & shift_q[8];
        end
        else if (rd_data_pop)
            rx_full_q <= 1'b0;
    end

    // overrun sticks until continuous receive is cleared
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            overrun_q <= 1'b0;
        else if (overrun_evt)
            overrun_q <= 1'b1;
        else if (!cont_rx)
            overrun_q <= 1'b0;
    end

    // sticky events; a set in the clear cycle wins over the clear
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            evt_status_q <= '0;
        else
        begin
            for (int i = 0; i < EV_W; i++)
            begin
                if ((i == EV_RX_DONE && rx_evt)
                    || (i == EV_FRAME_ERR && rx_evt && stop_bad)
                    || (i == EV_OVERRUN && overrun_evt))
                    evt_status_q[i] <= 1'b1;
                else if (wr_fire && wr_ok && wr_idx == IDX_EVT_CLEAR
                         && wdata_q[i])
                    evt_status_q[i] <= 1'b0;
            end
        end
    end

    // level interrupt: rx flag gated by its enable, plus event group
    assign irq_o = (rx_full_q & irq_enables_q[FLG_RX_FULL])
                   | (|(evt_status_q & evt_enable_q));
endmodule // async_serial_receiver

/* File: verification/serial_rx_asserts.sv */
// concurrent checks on the serial receiver top ports
module serial_rx_asserts
    import serial_rx_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              s_axi_awvalid,
    input  wire logic              s_axi_awready,
    input  wire logic              s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [31:0]       s_axi_rdata,
    input  wire logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_rx_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    // request steps as seen on the bus
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_flag_rd;
        s_rd_taken ##0 (s_axi_araddr == {IDX_IRQ_FLAGS, 2'b00});
    endsequence

    // write is performed one edge after both halves are held
    a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    // read answer comes one cycle after the address is taken
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    // read answer stands until taken, write answer drops once taken
    a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data did not stand");
    a_wr_drops: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write answer repeated");
    // no new request while an answer waits
    a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_wr_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_flag_zeros: assert property (s_flag_rd
        |=> s_axi_rdata[3] == 1'b0 && s_axi_rdata[31:8] == 24'h0)
        else $error("flag register unused bit set");
    a_pin_undriven: assert property (serial_rx_pin_oe_o == 1'b0)
        else $error("receive pin driven");
endmodule // serial_rx_asserts

/* File: verification/serial_line_model.sv */
// remote asynchronous transmitter on the receive line
module serial_line_model
#(
    parameter int BIT_CLKS = 16
)
(
    input  wire logic clk_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle level is high between frames
    initial line_o = 1'b1;

    // one bit time, driven just after an edge
    task automatic put(input logic b);
        line_o <= b;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask

    // start low, data lsb first, stop, then two idle bits
    task automatic send(input logic [8:0] d, input int nb, input logic stop);
        put(1'b0);
        for (int i = 0; i < nb; i++)
            put(d[i]);
        put(stop);
        put(1'b1);
        put(1'b1);
    endtask
endmodule // serial_line_model

/* File: verification/async_serial_receiver_tb.sv */
// self-checking bench for the serial receiver
module async_serial_receiver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_rx_pkg::*;

    logic              clk, rst_b, tx_emp, line, oe, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [31:0]       wdata, rdata;
    logic [1:0]        bresp, rresp;
    int                n_fail = 0;
    int                n_compared = 0;

    async_serial_receiver DUT (
        .core_clk_i(clk), .rst_b_i(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_rx_pin_i(line),
        .tx_buffer_empty_i(tx_emp), .serial_rx_pin_oe_o(oe),
        .irq_o(irq)
    );

    // divisor 0 with high speed gives 16 clocks a bit
    serial_line_model #(.BIT_CLKS(16)) line_tx (.clk_i(clk), .line_o(line));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a used-up wait counts as a mismatch and ends the run
    task automatic guard(input int n);
        if (n >= 99)
        begin
            n_fail++;
            complete_run();
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        int   n;
        logic a;
        logic w;
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        a = 1'b1;
        w = 1'b1;
        for (n = 0; n < 99 && (a || w); n++)
        begin
            @(posedge clk);
            a = a && (awready !== 1'b1);
            w = w && (wready !== 1'b1);
            awvalid <= a;
            wvalid  <= w;
        end
        guard(n);
        for (n = 0; n < 99 && bvalid !== 1'b1; n++)
            @(posedge clk);
        guard(n);
        // bready stays up: a next write would raise it in this same step
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    // ready raised late on purpose so the answer has to stand
    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        for (n = 0; n < 99; n++)
        begin
            @(posedge clk);
            if (arready === 1'b1)
                break;
        end
        guard(n);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rvalid !== 1'b1 && n < 99);
        guard(n);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rchk(input string nm, input logic [7:0] idx,
                        input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk(nm, {24'h0, e}, d);
    endtask

    task automatic endt(input string nm);
        $display("test %s done", nm);
    endtask

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = '0;
        tx_emp = 1'b1;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // reset values, read-only flags, unmapped place
        rchk("flags", IDX_IRQ_FLAGS, 8'h10);
        rchk("rx status", IDX_RX_STATUS, 8'h00);
        rchk("rx data", IDX_RX_DATA, 8'h00);
        rchk("enables", IDX_IRQ_ENABLES, 8'h00);
        rchk("tx status", IDX_TX_STATUS, 8'h02);
        rchk("baud", IDX_BAUD_DIV, 8'h00);
        wr(IDX_IRQ_FLAGS, 8'hff, AXI_OKAY);
        tx_emp <= 1'b0;
        rchk("flags ro", IDX_IRQ_FLAGS, 8'h00);
        wr(8'h50, 8'h00, AXI_SLVERR);
        rd(8'h50, d, r);
        chk("unmapped", {30'h0, AXI_SLVERR}, {30'h0, r});
        tx_emp <= 1'b1;
        endt("reset");
        // sync mode set: port is not asynchronous, frame ignored
        wr(IDX_TX_STATUS, 8'h14, AXI_OKAY);
        wr(IDX_RX_STATUS, 8'h90, AXI_OKAY);
        line_tx.send(9'h03c, 8, 1'b1);
        rchk("sync flags", IDX_IRQ_FLAGS, 8'h10);
        // divisor round trip while the port is still off
        wr(IDX_BAUD_DIV, 8'h5a, AXI_OKAY);
        rchk("baud wr", IDX_BAUD_DIV, 8'h5a);
        wr(IDX_BAUD_DIV, 8'h00, AXI_OKAY);
        wr(IDX_TX_STATUS, 8'h04, AXI_OKAY);
        rchk("tx cfg", IDX_TX_STATUS, 8'h06);
        endt("mode");
        // frame with interrupt disabled, then enabled late
        line_tx.send(9'h0a5, 8, 1'b1);
        rchk("rx flag", IDX_IRQ_FLAGS, 8'h30);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_ENABLES, 8'h20, AXI_OKAY);
        chk("irq on", 32'h1, {31'h0, irq});
        rchk("status", IDX_RX_STATUS, 8'h90);
        rchk("data", IDX_RX_DATA, 8'ha5);
        rchk("flag clr", IDX_IRQ_FLAGS, 8'h10);
        chk("irq off", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_ENABLES, 8'h00, AXI_OKAY);
        endt("frame");
        // nine bits, then a low stop bit
        wr(IDX_RX_STATUS, 8'hd0, AXI_OKAY);
        line_tx.send(9'h15a, 9, 1'b1);
        rchk("ninth", IDX_RX_STATUS, 8'hd1);
        rchk("data9", IDX_RX_DATA, 8'h5a);
        line_tx.send(9'h0c3, 9, 1'b0);
        rchk("frame err", IDX_RX_STATUS, 8'hd4);
        rchk("data fe", IDX_RX_DATA, 8'hc3);
        endt("nine");
        // overrun halts reception until continuous receive drops
        wr(IDX_RX_STATUS, 8'h90, AXI_OKAY);
        line_tx.send(9'h011, 8, 1'b1);
        line_tx.send(9'h022, 8, 1'b1);
        line_tx.send(9'h033, 8, 1'b1);
        rchk("overrun", IDX_RX_STATUS, 8'h92);
        rchk("kept", IDX_RX_DATA, 8'h11);
        wr(IDX_RX_STATUS, 8'h80, AXI_OKAY);
        rchk("ovr clr", IDX_RX_STATUS, 8'h80);
        line_tx.send(9'h044, 8, 1'b1);
        rchk("rx off", IDX_IRQ_FLAGS, 8'h10);
        endt("overrun");
        // sticky events: masked, stale ones cleared, raised, cleared
        rchk("events", IDX_EVT_STATUS, 8'h07);
        chk("ev masked", 32'h0, {31'h0, irq});
        wr(IDX_EVT_CLEAR, 8'h03, AXI_OKAY);
        rchk("ev stale", IDX_EVT_STATUS, 8'h04);
        wr(IDX_EVT_ENABLE, 8'h07, AXI_OKAY);
        chk("ev irq", 32'h1, {31'h0, irq});
        wr(IDX_EVT_CLEAR, 8'h07, AXI_OKAY);
        chk("ev cleared", 32'h0, {31'h0, irq});
        rchk("ev none", IDX_EVT_STATUS, 8'h00);
        endt("events");
        complete_run();
    end
endmodule // async_serial_receiver_tb

bind async_serial_receiver serial_rx_asserts u_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .serial_rx_pin_oe_o(serial_rx_pin_oe_o)
);
